// ==== verilog/rrs_pkg.sv ====
// constants and carrier types for the re-driver reset and strap block
// assumes a single 40 MHz core clock and a synchronous active-low reset
//
// Overview of operation
// - three-level address strap picks slave address 0101100, 0101101 or 0101110.
// - configuration registers are reachable only through the two-wire slave port.
// - device becomes ready about 400 ms after a valid reset release.
// - cable-adapter sense high forces TMDS mode regardless of the sink.
// - hot-plug sense high means a sink is present.
package rrs_pkg;
    localparam int unsigned CLK_HZ = 40_000_000;
    localparam int unsigned READY_MS = 400;
    localparam int unsigned READY_CYCLES = READY_MS * (CLK_HZ / 1000);
    localparam int unsigned SYNC_STAGES = 3;

    localparam logic [6:0] ADDR_STRAP_LOW = 7'h2C;
    localparam logic [6:0] ADDR_STRAP_MID = 7'h2D;
    localparam logic [6:0] ADDR_STRAP_HIGH = 7'h2E;

    // three-level strap arrives as two comparator outputs
    typedef struct packed {
        logic above_low;
        logic above_mid;
    } rrs_strap_t;

    typedef struct packed {
        logic tmds_mode;
        logic sink_present;
    } rrs_link_t;

    typedef enum logic [1:0] {
        RRS_IN_RESET,
        RRS_WARMUP,
        RRS_READY
    } rrs_state_t;
endpackage : rrs_pkg

// ==== verilog/rrs_sync.sv ====
// three-stage synchroniser for slow pin inputs
// assumes inputs are asynchronous levels; output moves only when stages 2,3 agree
module rrs_sync #(
    parameter int unsigned WIDTH = 1
) (
    input wire logic core_clk_in,
    input wire logic chip_reset_low_in,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] s2_q;
    logic [WIDTH-1:0] s3_q;

    if (WIDTH < 1) begin : g_bad_width
        $error("WIDTH must be at least one");
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge core_clk_in) begin
        if (!chip_reset_low_in) begin
            meta_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
        end else begin
            meta_q <= async_in;
            s2_q <= meta_q;
            s3_q <= s2_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // filter stage: first flop is read only by the second
    genvar gi;
    generate
        for (gi = 0; gi < WIDTH; gi++) begin : g_bit
            always_ff @(posedge core_clk_in) begin
                if (!chip_reset_low_in) begin
                    sync_out[gi] <= 1'b0;
                end else if (s2_q[gi] == s3_q[gi]) begin
                    sync_out[gi] <= s3_q[gi];
                end
            end
        end
    endgenerate
endmodule : rrs_sync

// ==== verilog/rrs_top.sv ====
// reset sequencing, address strap capture and sense decoding
// assumes the system controller orders supplies and holds chip_reset_low_in low
// until supplies settle; this block only sees the released reset
module rrs_top
    import rrs_pkg::*;
#(
    parameter int unsigned READY_COUNT = READY_CYCLES
) (
    input wire logic core_clk_in,
    input wire logic chip_reset_low_in,
    input wire rrs_strap_t address_strap_pin_in,
    input wire logic cable_adapter_sense_in,
    input wire logic hot_plug_sense_in,
    output logic [6:0] slave_addr_out,
    output logic addr_valid_out,
    output rrs_link_t link_mode_out,
    output logic ready_out,
    output logic ctrl_port_enable_out
);
    // the strap latch needs the counter to get past the synchroniser depth
    if (READY_COUNT < SYNC_STAGES + 1) begin : g_bad_ready_count
        $error("READY_COUNT must exceed the synchroniser depth");
    end

    localparam int unsigned CW = $clog2(READY_COUNT + 1);
    localparam logic [CW-1:0] READY_LAST = CW'(READY_COUNT - 1);

    logic [3:0] pins_sync;
    rrs_state_t state_q;
    logic [CW-1:0] count_q;
    logic strap_taken_q;

    ////////////////////////////////////////////////////////////////////////
    rrs_sync #(
        .WIDTH(4)
    ) u_sync (
        .core_clk_in(core_clk_in),
        .chip_reset_low_in(chip_reset_low_in),
        .async_in({address_strap_pin_in, cable_adapter_sense_in,
                   hot_plug_sense_in}),
        .sync_out(pins_sync)
    );

    ////////////////////////////////////////////////////////////////////////
    // readiness sequencer; reset is active low
    always_ff @(posedge core_clk_in) begin
        if (!chip_reset_low_in) begin
            state_q <= RRS_IN_RESET;
        end else begin
            case (state_q)
                RRS_IN_RESET: state_q <= RRS_WARMUP;
                RRS_WARMUP: begin
                    if (count_q == READY_LAST) begin
                        state_q <= RRS_READY;
                    end
                end
                RRS_READY: state_q <= RRS_READY;
                default: state_q <= RRS_IN_RESET;
            endcase
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (!chip_reset_low_in) begin
            count_q <= '0;
        end else if (state_q == RRS_WARMUP && count_q != READY_LAST) begin
            count_q <= count_q + CW'(1);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // strap is latched once, after the synchroniser has settled past reset
    always_ff @(posedge core_clk_in) begin
        if (!chip_reset_low_in) begin
            strap_taken_q <= 1'b0;
            slave_addr_out <= ADDR_STRAP_LOW;
        end else if (!strap_taken_q && count_q == CW'(SYNC_STAGES)) begin
            strap_taken_q <= 1'b1;
            if (pins_sync[2]) begin
                slave_addr_out <= ADDR_STRAP_HIGH;
            end else if (pins_sync[3]) begin
                slave_addr_out <= ADDR_STRAP_MID;
            end else begin
                slave_addr_out <= ADDR_STRAP_LOW;
            end
        end
    end

    // small READY_COUNT may reach ready before the strap window; gate it
    assign addr_valid_out = strap_taken_q;

    ////////////////////////////////////////////////////////////////////////
    // sense pins are static straps, so sampled levels map straight through
    always_ff @(posedge core_clk_in) begin
        if (!chip_reset_low_in) begin
            link_mode_out <= '0;
        end else begin
            link_mode_out.tmds_mode <= pins_sync[1];
            link_mode_out.sink_present <= pins_sync[0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // the two-wire slave is the only register path; held off until ready
    always_ff @(posedge core_clk_in) begin
        if (!chip_reset_low_in) begin
            ready_out <= 1'b0;
        end else begin
            ready_out <= (state_q == RRS_READY) && strap_taken_q;
        end
    end

    assign ctrl_port_enable_out = ready_out;
endmodule : rrs_top

// ==== bench/rrs_rst_ctl.sv ====
// reset controller model for the strap block
// assumes supplies are good whenever it lets reset go
module rrs_rst_ctl (
    input wire logic clk_in,
    input wire logic req_in,
    output logic chip_reset_low_out
);
    timeunit 1ns;
    timeprecision 100ps;
    int n = 10;
    logic core_supply_rail = 1'b0;
    logic io_supply_rail = 1'b0;
    // scaled spans; reset falls on the request edge, rails drop one edge later
    always @(posedge clk_in) n <= req_in ? 10 : (n > 0 ? n - 1 : 0);
    // core rail comes back two edges ahead of the I/O rail
    always @(posedge clk_in) core_supply_rail <= (n <= 8);
    always @(posedge clk_in) io_supply_rail <= core_supply_rail && n <= 6;
    // release only once both rails have been good for several edges
    assign chip_reset_low_out = (n == 0) && io_supply_rail;
endmodule : rrs_rst_ctl

// ==== bench/rrs_top_sva.sv ====
// port checker for rrs_top
// assumes one clock and the bind at the foot of this file
module rrs_top_sva
    import rrs_pkg::*;
#(
    parameter int unsigned READY_COUNT = READY_CYCLES
) (
    input wire logic core_clk_in,
    input wire logic chip_reset_low_in,
    input wire rrs_strap_t address_strap_pin_in,
    input wire logic cable_adapter_sense_in,
    input wire logic hot_plug_sense_in,
    input wire logic [6:0] slave_addr_out,
    input wire logic addr_valid_out,
    input wire rrs_link_t link_mode_out,
    input wire logic ready_out,
    input wire logic ctrl_port_enable_out
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (!chip_reset_low_in);
    int unsigned up_q;
    always_ff @(posedge core_clk_in) up_q <= chip_reset_low_in ? up_q + 1 : 0;
    AST_READY_TIME: assert property ($rose(ready_out) |->
        up_q >= READY_COUNT && up_q <= READY_COUNT + 4) else $error("ready time");
    AST_READY_HOLD: assert property (ready_out |=> ready_out)
        else $error("ready dropped");
    AST_READY_VALID: assert property (ready_out |-> addr_valid_out)
        else $error("ready before address");
    AST_PORT: assert property (ctrl_port_enable_out == ready_out)
        else $error("port enable");
    AST_ADDR_HOLD: assert property (addr_valid_out |=>
        $stable(slave_addr_out) && addr_valid_out) else $error("address moved");
    AST_ADDR_MAP: assert property ($rose(addr_valid_out) |->
        slave_addr_out == ($past(address_strap_pin_in.above_mid, 6) ?
        ADDR_STRAP_HIGH : $past(address_strap_pin_in.above_low, 6) ?
        ADDR_STRAP_MID : ADDR_STRAP_LOW))
        else $error("address map");
    AST_TMDS: assert property (cable_adapter_sense_in [*7] |->
        link_mode_out.tmds_mode) else $error("tmds mode");
    AST_SINK: assert property (hot_plug_sense_in [*7] |->
        link_mode_out.sink_present) else $error("sink present");
    AST_LINK_OFF: assert property ((!cable_adapter_sense_in &&
        !hot_plug_sense_in) [*7] |-> link_mode_out == 2'b00)
        else $error("link mode idle");
endmodule : rrs_top_sva
bind rrs_top rrs_top_sva #(.READY_COUNT(READY_COUNT)) u_sva (.core_clk_in,
    .chip_reset_low_in, .address_strap_pin_in, .cable_adapter_sense_in,
    .hot_plug_sense_in, .slave_addr_out, .addr_valid_out, .link_mode_out,
    .ready_out, .ctrl_port_enable_out);

// ==== bench/rrs_top_test.sv ====
// self-checking bench for rrs_top with a short warm-up count
// assumes rrs_rst_ctl drives the reset pin
module rrs_top_test;
    timeunit 1ns;
    timeprecision 100ps;
    import rrs_pkg::*;
    localparam int unsigned RC = 20;
    logic clk = 0, req = 0, cad = 0, hpd = 0, chip_reset_low, valid, ready, port_en;
    rrs_strap_t strap = 2'b00;
    logic [6:0] addr;
    rrs_link_t link;
    int n_errors = 0, checks_done = 0;
    always #12.5 clk = ~clk;
    rrs_rst_ctl u_rst (.clk_in(clk), .req_in(req), .chip_reset_low_out(chip_reset_low));
    rrs_top #(.READY_COUNT(RC)) u_dut (.core_clk_in(clk), .chip_reset_low_in(chip_reset_low),
        .address_strap_pin_in(strap), .cable_adapter_sense_in(cad),
        .hot_plug_sense_in(hpd), .slave_addr_out(addr),
        .addr_valid_out(valid), .link_mode_out(link), .ready_out(ready),
        .ctrl_port_enable_out(port_en));
    ////////////////////////////////////////////////////////////////////////
    task cmp_addr(input logic [6:0] got, input logic [6:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: address %h", $time, got);
        end
    endtask : cmp_addr
    task cmp_flag(input logic [1:0] got, input logic [1:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: flags %b", $time, got);
        end
    endtask : cmp_flag
    task end_of_test;
        if (n_errors == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : end_of_test
    // strap is set with the reset request, half a clock before reset falls, then moved after the latch
    task t_strap(input rrs_strap_t s, input logic [6:0] exp);
        int n;
        @(negedge clk);
        strap = s;
        req = 1;
        @(negedge clk);
        req = 0;
        while (!chip_reset_low) @(negedge clk);
        n = 0;
        while (ready !== 1'b1 && n < 100) begin
            @(negedge clk);
            n++;
        end
        cmp_flag({1'b0, n >= RC && n <= RC + 4}, 2'b01);
        cmp_addr(addr, exp);
        cmp_flag({valid, port_en}, 2'b11);
        strap = ~s;
        repeat (8) @(negedge clk);
        cmp_addr(addr, exp);
    endtask : t_strap
    task t_sense;
        for (int i = 0; i < 4; i++) begin
            {cad, hpd} = i[1:0];
            repeat (8) @(negedge clk);
            cmp_flag(link, i[1:0]);
        end
    endtask : t_sense
    initial begin
        repeat (10) @(negedge clk);
        t_strap(2'b00, ADDR_STRAP_LOW);
        t_strap(2'b10, ADDR_STRAP_MID);
        t_strap(2'b01, ADDR_STRAP_HIGH);
        t_strap(2'b11, ADDR_STRAP_HIGH);
        t_sense;
        end_of_test;
    end
    initial begin
        #20000;
        n_errors++;
        end_of_test;
    end
endmodule : rrs_top_test
